// File: verilog/idb_pkg.sv
/*
 * Package for the increment/decrement, skip, interrupt-gate and
 * indirect-jump execution block: register map, field positions,
 * reset values, operation codes and timing counts.
 * Assumes a single 40 MHz core clock and an Avalon-MM master.
 */
`default_nettype none

package idb_pkg;

    // Core clock and instruction cycle
    localparam int CORE_CLK_HZ       = 40_000_000;
    localparam int INSTR_CYCLE_NS    = 100;
    localparam int INSTR_CYCLE_CLKS  = (INSTR_CYCLE_NS * (CORE_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int DIV_W             = 3;

    // Register offsets (byte addresses)
    localparam logic [4:0] CMD_OFS    = 5'h00;
    localparam logic [4:0] WORK_OFS   = 5'h04;
    localparam logic [4:0] TBL_PTR_OFS = 5'h08;
    localparam logic [4:0] STAT_OFS   = 5'h0C;
    localparam logic [4:0] PC_OFS     = 5'h10;
    localparam logic [4:0] FADDR_OFS  = 5'h14;
    localparam logic [4:0] FDATA_OFS  = 5'h18;

    // Command register fields
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_DEST_BIT = 3;
    localparam int CMD_REG_LSB  = 4;

    // Status register fields
    localparam int STAT_NULL_BIT = 0;
    localparam int STAT_IRQ_EN_BIT = 1;
    localparam int STAT_BUSY_BIT = 2;
    localparam int STAT_SKIP_BIT = 3;

    // Reset values, step constants and file depth
    localparam logic [7:0]  WORK_RST  = 8'h00;
    localparam logic [2:0]  TBL_PTR_RST = 3'h0;
    localparam logic [10:0] PC_RST    = 11'h000;
    localparam logic        IRQ_EN_RST = 1'b0;
    localparam logic [7:0]  FILE_RST  = 8'h00;
    localparam logic [7:0]  ZERO_BYTE = 8'h00;
    localparam logic [7:0]  ONE_BYTE  = 8'h01;
    localparam logic [10:0] PC_ONE    = 11'h001;
    localparam logic [10:0] PC_TWO    = 11'h002;
    localparam int          FILE_DEPTH = 128;

    // Operation codes written to the command register
    typedef enum logic [2:0] {
        IDB_OP_NOP,
        IDB_OP_MINUS_ONE,
        IDB_OP_PLUS_ONE,
        IDB_OP_PLUS_ONE_SKIP,
        IDB_OP_MINUS_ONE_SKIP,
        IDB_OP_IRQ_MASK_ALL,
        IDB_OP_IRQ_UNMASK_ALL,
        IDB_OP_JUMP_VIA_WORK
    } idb_op_t;

    // Decoded command
    typedef struct packed {
        idb_op_t    op;
        logic       dest_file;
        logic [6:0] reg_addr;
    } idb_cmd_t;

endpackage

`default_nettype wire

// File: verilog/idb_core.sv
/*
 * Execution block for register plus/minus one with destination select,
 * plus/minus one with skip on null result, global interrupt mask and
 * unmask, and the jump through table high pointer and work register.
 * Assumes an Avalon-MM master with waitrequest on core_clk and an
 * asynchronous interrupt request pin.
 */
// Functional notes
// RULE1 - Minus one, result to work or file
// RULE2 - Null flag set when result is zero
// RULE3 - Plus one, result to work or file
// RULE4 - 0xFF plus one wraps to zero
// RULE5 - Mask-all clears global enable in one cycle
// RULE6 - Unmask-all sets global enable in one cycle
// RULE7 - Jump loads pointer bits and work register
// RULE8 - Jump is unconditional, two cycles
// RULE9 - Plus-one-skip increments, routes by destination bit
// RULE10 - Null result discards next, runs no-op
// RULE11 - Continue after the skipped instruction
// RULE12 - Minus-one-skip decrements, routes, skips on null
// RULE13 - No vectoring while global enable is low
`default_nettype none

module idb_core (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         srst,
    // Avalon-MM slave
    input  wire logic [4:0]   avs_address,
    input  wire logic         avs_read,
    input  wire logic         avs_write,
    input  wire logic [31:0]  avs_writedata,
    output logic      [31:0]  avs_readdata,
    output logic              avs_waitrequest,
    // Interrupt request pin and vector request
    input  wire logic         irq_req_pin,
    output logic              irq_vector_take
);

    // Byte arithmetic shared by the plus and minus paths
    function automatic logic [7:0] step_byte(input logic [7:0] v, input logic up);
        logic [7:0] r;
        r = up ? v + idb_pkg::ONE_BYTE : v - idb_pkg::ONE_BYTE;
        return r;
    endfunction

    typedef enum logic [1:0] {
        IDB_ST_IDLE,
        IDB_ST_EXEC,
        IDB_ST_SECOND
    } idb_state_t;

    idb_state_t         state_ff;
    idb_pkg::idb_cmd_t  cmd_ff;
    logic [7:0]         work_ff;
    logic [2:0]         tbl_ptr_ff;
    logic [10:0]        pc_ff;
    logic               null_ff;
    logic               irq_en_ff;
    logic               skip_ff;
    logic [6:0]         faddr_ff;
    logic [7:0]         file_ff [idb_pkg::FILE_DEPTH];
    logic [idb_pkg::DIV_W-1:0] div_ff;
    logic               tick_ff;
    logic               irq_meta_ff;
    logic               irq_sync_ff;
    logic               wait_ff;
    logic [31:0]        rdata_ff;
    logic               irq_take_ff;

    logic               bus_wr;
    logic               bus_req;
    logic               exec_now;
    logic               arith_op;
    logic               arith_up;
    logic               skip_op;
    logic [7:0]         arith_res;
    logic               res_null;
    logic [31:0]        nxt_rdata;

    assign bus_req  = (avs_read || avs_write) && wait_ff;
    assign bus_wr   = avs_write && !wait_ff;
    assign exec_now = (state_ff == IDB_ST_EXEC) && tick_ff;

    // Decode of the pending operation
    always_comb begin
        arith_op = 1'b0;
        arith_up = 1'b0;
        skip_op  = 1'b0;
        case (cmd_ff.op)
            idb_pkg::IDB_OP_MINUS_ONE: begin
                arith_op = 1'b1;
            end
            idb_pkg::IDB_OP_PLUS_ONE: begin
                arith_op = 1'b1;
                arith_up = 1'b1;
            end
            idb_pkg::IDB_OP_PLUS_ONE_SKIP: begin
                arith_op = 1'b1;
                arith_up = 1'b1;
                skip_op  = 1'b1;
            end
            idb_pkg::IDB_OP_MINUS_ONE_SKIP: begin
                arith_op = 1'b1;
                skip_op  = 1'b1;
            end
            default: begin
                arith_op = 1'b0;
            end
        endcase
    end

    // RULE4 - eight-bit wrap
    assign arith_res = step_byte(file_ff[cmd_ff.reg_addr], arith_up);
    // RULE2 - null detect
    assign res_null  = (arith_res == idb_pkg::ZERO_BYTE);

    localparam int DIV_W = idb_pkg::DIV_W;

    // Instruction cycle enable
    always_ff @(posedge core_clk) begin
        if (srst) begin
            div_ff  <= '0;
            tick_ff <= 1'b0;
        end else if (div_ff == DIV_W'(idb_pkg::INSTR_CYCLE_CLKS - 1)) begin
            div_ff  <= '0;
            tick_ff <= 1'b1;
        end else begin
            div_ff  <= div_ff + DIV_W'(1);
            tick_ff <= 1'b0;
        end
    end

    // Execution sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_ff <= IDB_ST_IDLE;
            cmd_ff   <= '0;
            skip_ff  <= 1'b0;
        end else begin
            case (state_ff)
                IDB_ST_IDLE: begin
                    if (bus_wr && avs_address == idb_pkg::CMD_OFS) begin
                        cmd_ff.op        <= idb_pkg::idb_op_t'(
                            avs_writedata[idb_pkg::CMD_OP_LSB +: 3]);
                        cmd_ff.dest_file <= avs_writedata[idb_pkg::CMD_DEST_BIT];
                        cmd_ff.reg_addr  <= avs_writedata[idb_pkg::CMD_REG_LSB +: 7];
                        skip_ff          <= 1'b0;
                        state_ff         <= IDB_ST_EXEC;
                    end
                end
                IDB_ST_EXEC: begin
                    if (tick_ff) begin
                        // RULE8 - jump takes two cycles
                        if (cmd_ff.op == idb_pkg::IDB_OP_JUMP_VIA_WORK) begin
                            state_ff <= IDB_ST_SECOND;
                        // RULE10 - null result inserts no-op
                        end else if (skip_op && res_null) begin
                            skip_ff  <= 1'b1;
                            state_ff <= IDB_ST_SECOND;
                        end else begin
                            state_ff <= IDB_ST_IDLE;
                        end
                    end
                end
                IDB_ST_SECOND: begin
                    if (tick_ff) begin
                        state_ff <= IDB_ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= IDB_ST_IDLE;
                end
            endcase
        end
    end

    // Work register
    always_ff @(posedge core_clk) begin
        if (srst) begin
            work_ff <= idb_pkg::WORK_RST;
        // RULE1 - minus one to work
        // RULE3 - plus one to work
        // RULE9 - skip forms route by destination
        end else if (exec_now && arith_op && !cmd_ff.dest_file) begin
            work_ff <= arith_res;
        end else if (bus_wr && avs_address == idb_pkg::WORK_OFS) begin
            work_ff <= avs_writedata[7:0];
        end
    end

    // Register file
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < idb_pkg::FILE_DEPTH; i++) begin
                file_ff[i] <= idb_pkg::FILE_RST;
            end
        // RULE12 - minus-one-skip writes back
        end else if (exec_now && arith_op && cmd_ff.dest_file) begin
            file_ff[cmd_ff.reg_addr] <= arith_res;
        end else if (bus_wr && avs_address == idb_pkg::FDATA_OFS) begin
            file_ff[faddr_ff] <= avs_writedata[7:0];
        end
    end

    // Null result flag
    always_ff @(posedge core_clk) begin
        if (srst) begin
            null_ff <= 1'b0;
        // RULE2 - flag update
        end else if (exec_now && arith_op) begin
            null_ff <= res_null;
        end
    end

    // Global interrupt enable
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_en_ff <= idb_pkg::IRQ_EN_RST;
        // RULE5 - mask all
        end else if (exec_now && cmd_ff.op == idb_pkg::IDB_OP_IRQ_MASK_ALL) begin
            irq_en_ff <= 1'b0;
        // RULE6 - unmask all
        end else if (exec_now && cmd_ff.op == idb_pkg::IDB_OP_IRQ_UNMASK_ALL) begin
            irq_en_ff <= 1'b1;
        end
    end

    // Program counter and pointer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pc_ff   <= idb_pkg::PC_RST;
            tbl_ptr_ff <= idb_pkg::TBL_PTR_RST;
        end else begin
            if (bus_wr && avs_address == idb_pkg::TBL_PTR_OFS) begin
                tbl_ptr_ff <= avs_writedata[2:0];
            end
            if (exec_now) begin
                if (cmd_ff.op == idb_pkg::IDB_OP_JUMP_VIA_WORK) begin
                    // RULE7 - load pointer and work
                    pc_ff <= {tbl_ptr_ff, work_ff};
                end else if (skip_op && res_null) begin
                    // RULE11 - step over skipped slot
                    pc_ff <= pc_ff + idb_pkg::PC_TWO;
                end else begin
                    pc_ff <= pc_ff + idb_pkg::PC_ONE;
                end
            end
        end
    end

    // File address pointer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            faddr_ff <= '0;
        end else if (bus_wr && avs_address == idb_pkg::FADDR_OFS) begin
            faddr_ff <= avs_writedata[6:0];
        end
    end

    // Interrupt pin synchroniser and gate
    always_ff @(posedge core_clk) begin
        if (srst) begin
            irq_meta_ff <= 1'b0;
            irq_sync_ff <= 1'b0;
            irq_take_ff <= 1'b0;
        end else begin
            irq_meta_ff <= irq_req_pin;
            irq_sync_ff <= irq_meta_ff;
            // RULE13 - gate by global enable
            irq_take_ff <= irq_sync_ff && irq_en_ff;
        end
    end

    // Read mux
    always_comb begin
        nxt_rdata = '0;
        if (avs_address == idb_pkg::CMD_OFS) begin
            nxt_rdata = {21'h00_0000, cmd_ff.reg_addr, cmd_ff.dest_file, cmd_ff.op};
        end else if (avs_address == idb_pkg::WORK_OFS) begin
            nxt_rdata = {24'h00_0000, work_ff};
        end else if (avs_address == idb_pkg::TBL_PTR_OFS) begin
            nxt_rdata = {29'h0000_0000, tbl_ptr_ff};
        end else if (avs_address == idb_pkg::STAT_OFS) begin
            nxt_rdata[idb_pkg::STAT_NULL_BIT] = null_ff;
            nxt_rdata[idb_pkg::STAT_IRQ_EN_BIT] = irq_en_ff;
            nxt_rdata[idb_pkg::STAT_BUSY_BIT] = (state_ff != IDB_ST_IDLE);
            nxt_rdata[idb_pkg::STAT_SKIP_BIT] = skip_ff;
        end else if (avs_address == idb_pkg::PC_OFS) begin
            nxt_rdata = {21'h00_0000, pc_ff};
        end else if (avs_address == idb_pkg::FADDR_OFS) begin
            nxt_rdata = {25'h000_0000, faddr_ff};
        end else if (avs_address == idb_pkg::FDATA_OFS) begin
            nxt_rdata = {24'h00_0000, file_ff[faddr_ff]};
        end
    end

    // Bus handshake: one wait cycle per access
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wait_ff  <= 1'b1;
            rdata_ff <= '0;
        end else begin
            wait_ff <= !bus_req;
            if (bus_req && avs_read) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign avs_readdata    = rdata_ff;
    assign avs_waitrequest = wait_ff;
    assign irq_vector_take = irq_take_ff;

endmodule

`default_nettype wire

// File: bench/idb_core_asserts.sv
/* Port checks of idb_core: bus handshake, read data, interrupt gate.
   Assumes a bind to idb_core and a master that holds each request. */
`default_nettype none
module idb_core_asserts (
    // Clock and reset
    input wire logic        core_clk,
    input wire logic        srst,
    // Register bus
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Interrupt
    input wire logic        irq_req_pin,
    input wire logic        irq_vector_take
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       cmd_done;
    logic [2:0] cmd_op;
    logic       unmasked_ff;
    logic       rd_ans;
    assign cmd_done = avs_write && !avs_waitrequest && avs_address == idb_pkg::CMD_OFS;
    assign cmd_op = avs_writedata[2:0];
    assign rd_ans = avs_read && !avs_waitrequest;
    // Any unmask command since reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            unmasked_ff <= 1'b0;
        end else if (cmd_done && cmd_op == 3'h6) begin
            unmasked_ff <= 1'b1;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    one_wait_a: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer one cycle after request");
    single_low_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low two cycles");
    answer_asked_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    upper_zero_a: assert property (rd_ans |-> avs_readdata[31:11] == 21'h0)
        else $error("upper read bits not zero");
    unmapped_zero_a: assert property (
        rd_ans && (avs_address > 5'h18 || avs_address[1:0] != 2'h0) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    take_needs_pin_a: assert property (
        irq_vector_take |-> $past(irq_req_pin, 2) || $past(irq_req_pin, 3))
        else $error("vector taken without request");
    take_after_unmask_a: assert property (irq_vector_take |-> unmasked_ff)
        else $error("vector taken before any unmask");
    mask_blocks_a: assert property (
        cmd_done && cmd_op == 3'h5 |-> ##6 !irq_vector_take)
        else $error("vector taken after mask-all");
endmodule
`default_nettype wire

// File: bench/tb_inc_dec_branch_irq_instructions.sv
/* Self-checking bench for idb_core: all op codes, wrap and null cases.
   Assumes idb_pkg and the checker module are compiled first. */
`default_nettype none
module tb_inc_dec_branch_irq_instructions;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk;
    logic        srst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq_req_pin;
    logic        irq_vector_take;
    logic [31:0] rd;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic        null_e;
    logic        irq_en_e;
    logic [10:0] pc_e;
    int          num_errors;
    int          total_checks;

    idb_core i_dut (
        .core_clk        (core_clk),
        .srst            (srst),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .irq_req_pin     (irq_req_pin),
        .irq_vector_take (irq_vector_take)
    );

    task automatic close_out();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
        total_checks++;
        if (((g ^ e) & m) !== 32'h0000_0000) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= !wr;
        avs_writedata <= d;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic rdx(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0000_0000);
    endtask

    // Polls status until the busy bit drops
    task automatic idle();
        do begin
            rdx(idb_pkg::STAT_OFS, 32'h0, 32'h0);
        end while (rd[idb_pkg::STAT_BUSY_BIT] !== 1'b0);
    endtask

    task automatic run(input logic [2:0] op, input logic d, input logic [7:0] v);
        logic [7:0]  w;
        logic [7:0]  res;
        logic [7:0]  tb;
        logic [6:0]  r;
        logic [10:0] pce;
        logic        sk;
        logic        arith;
        w = 8'($urandom);
        tb = 8'($urandom);
        r = 7'($urandom);
        arith = op >= 3'h1 && op <= 3'h4;
        res = (op == 3'h2 || op == 3'h3) ? v + 8'h01 : v - 8'h01;
        sk = (op == 3'h3 || op == 3'h4) && res == 8'h00;
        bus(1'b1, idb_pkg::FADDR_OFS, {25'h0, r});
        bus(1'b1, idb_pkg::FDATA_OFS, {24'h0, v});
        bus(1'b1, idb_pkg::WORK_OFS, {24'h0, w});
        bus(1'b1, idb_pkg::TBL_PTR_OFS, {24'h0, tb});
        rdx(idb_pkg::PC_OFS, {21'h0, pc_e}, 32'h0000_07ff);
        pce = (op == 3'h7) ? {tb[2:0], w} : pc_e + (sk ? 11'h002 : 11'h001);
        pc_e = pce;
        bus(1'b1, idb_pkg::CMD_OFS, {21'h0, r, d, op});
        // Second poll samples five clocks after the command commits
        rdx(idb_pkg::STAT_OFS, 32'h0, 32'h0);
        rdx(idb_pkg::STAT_OFS, {29'h0, op == 3'h7 || sk, 2'h0}, 32'h0000_0004);
        idle();
        rdx(idb_pkg::CMD_OFS, {21'h0, r, d, op}, 32'hffff_ffff);
        null_e = arith ? res == 8'h00 : null_e;
        irq_en_e = (op == 3'h6) || (irq_en_e && op != 3'h5);
        rdx(idb_pkg::PC_OFS, {21'h0, pce}, 32'h0000_07ff);
        rdx(idb_pkg::STAT_OFS, {28'h0, sk, 1'b0, irq_en_e, null_e},
            {28'h0, op == 3'h3 || op == 3'h4, 3'h7});
        if (arith) begin
            rdx(idb_pkg::WORK_OFS, {24'h0, d ? w : res}, 32'h0000_00ff);
            rdx(idb_pkg::FDATA_OFS, {24'h0, d ? res : v}, 32'h0000_00ff);
        end else begin
            irq_req_pin <= 1'b1;
            repeat (6) @(posedge core_clk);
            cmp({31'h0, irq_en_e}, 32'h0000_0001, {31'h0, irq_vector_take});
            irq_req_pin <= 1'b0;
            repeat (6) @(posedge core_clk);
        end
    endtask

    // Read answers checked against the oldest note
    always @(posedge core_clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            cmp(exp_q.pop_front(), msk_q.pop_front(), avs_readdata);
        end
    end

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        close_out();
    end

    initial begin
        logic [7:0] edge_v [4];
        logic [2:0] seq [7];
        edge_v = '{8'hff, 8'h01, 8'h00, 8'h80};
        seq = '{3'h6, 3'h0, 3'h7, 3'h5, 3'h7, 3'h6, 3'h5};
        srst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        irq_req_pin = 1'b0;
        null_e = 1'b0;
        irq_en_e = 1'b0;
        pc_e = idb_pkg::PC_RST;
        num_errors = 0;
        total_checks = 0;
        void'($urandom(32'h00f3_6223));
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        rdx(idb_pkg::STAT_OFS, 32'h0, 32'h0000_000f);
        rdx(idb_pkg::PC_OFS, 32'h0, 32'h0000_07ff);
        bus(1'b1, 5'h1c, $urandom);
        rdx(5'h1c, 32'h0, 32'hffff_ffff);
        for (int op = 1; op <= 4; op++) begin
            for (int i = 0; i < 8; i++) begin
                run(3'(op), i[0], i[2:1] == 2'h3 ? 8'($urandom) : edge_v[i[2:1]]);
            end
        end
        foreach (seq[k]) begin
            run(seq[k], 1'b0, 8'h00);
        end
        close_out();
    end
endmodule

bind idb_core idb_core_asserts i_chk (
    .core_clk        (core_clk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .irq_req_pin     (irq_req_pin),
    .irq_vector_take (irq_vector_take)
);
`default_nettype wire
